// ==== rtl/rxmf_defs.vh ====
`ifndef RXMF_DEFS_VH
`define RXMF_DEFS_VH
// Register indices; byte address is four times the index.
`define RXMF_IDX_HASH 12'h080
`define RXMF_HASH_WORDS 12'h020
`define RXMF_IDX_VAL01 12'h100
`define RXMF_IDX_VAL45 12'h200
`define RXMF_IDX_MASK 12'h300
`define RXMF_IDX_LEN03 12'h380
`define RXMF_IDX_LEN45 12'h388
`define RXMF_IDX_LEN67 12'h38c
`define RXMF_IDX_VAL67 12'h400
`define RXMF_IDX_VAL89 12'h900
`define RXMF_IDX_MASK89 12'hb00
`define RXMF_IDX_LEN89 12'hb80
`define RXMF_IDX_CTRL 12'h010
`define RXMF_IDX_CTRL2 12'h011
`define RXMF_IDX_STATUS 12'h012
`define RXMF_IDX_MCCTL 12'h013
`define RXMF_TABLE_SPAN 12'h080
`define RXMF_VAL_SPAN 12'h100
// Field positions and widths.
`define RXMF_LEN_W 11
`define RXMF_MCCTL_HIT_BIT 8
`define RXMF_FLEX_BYTES 11'h080
`define RXMF_DEST_LAST_POS 11'h005
// Decoder kinds.
`define RXMF_K_NONE 4'h0
`define RXMF_K_HASH 4'h1
`define RXMF_K_VAL 4'h2
`define RXMF_K_MASK 4'h3
`define RXMF_K_MASK89 4'h4
`define RXMF_K_LEN 4'h5
`define RXMF_K_CTRL 4'h6
`define RXMF_K_CTRL2 4'h7
`define RXMF_K_STATUS 4'h8
`define RXMF_K_MCCTL 4'h9
// Reset values and responses.
`define RXMF_CTRL_RST 8'h00
`define RXMF_CTRL2_RST 2'h0
`define RXMF_MCOFF_RST 2'h0
`define RXMF_RESP_OKAY 2'h0
`define RXMF_RESP_SLVERR 2'h2
`endif

// ==== rtl/rxmf_filter.v ====
`timescale 1ns/1ps
`include "rxmf_defs.vh"
module rxmf_filter (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire [13:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [13:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_last,
   output reg mc_hit_reg,
   output reg [9:0] flex_pass_reg
);

   // Returns {kind, select, entry} for a register index.
   function [14:0] rxmf_decode;
      input [11:0] ix;
      begin
         rxmf_decode = {`RXMF_K_NONE, 4'h0, 7'h00};
         if (ix >= `RXMF_IDX_HASH && ix < `RXMF_IDX_HASH + `RXMF_HASH_WORDS) begin
            rxmf_decode = {`RXMF_K_HASH, 4'h0, 2'b00, ix[4:0]};
         end else if (ix >= `RXMF_IDX_VAL01 && ix < `RXMF_IDX_VAL01 + `RXMF_VAL_SPAN) begin
            rxmf_decode = {`RXMF_K_VAL, 3'h0, ix[0], ix[7:1]};
         end else if (ix >= `RXMF_IDX_VAL45 && ix < `RXMF_IDX_VAL45 + `RXMF_VAL_SPAN && !ix[0]) begin
            rxmf_decode = {`RXMF_K_VAL, 4'h2, ix[7:1]};
         end else if (ix >= `RXMF_IDX_VAL67 && ix < `RXMF_IDX_VAL67 + `RXMF_VAL_SPAN && !ix[0]) begin
            rxmf_decode = {`RXMF_K_VAL, 4'h3, ix[7:1]};
         end else if (ix >= `RXMF_IDX_VAL89 && ix < `RXMF_IDX_VAL89 + `RXMF_VAL_SPAN && !ix[0]) begin
            rxmf_decode = {`RXMF_K_VAL, 4'h4, ix[7:1]};
         end else if (ix >= `RXMF_IDX_MASK && ix < `RXMF_IDX_MASK + `RXMF_TABLE_SPAN) begin
            rxmf_decode = {`RXMF_K_MASK, 4'h0, ix[6:0]};
         end else if (ix >= `RXMF_IDX_MASK89 && ix < `RXMF_IDX_MASK89 + `RXMF_TABLE_SPAN) begin
            rxmf_decode = {`RXMF_K_MASK89, 4'h0, ix[6:0]};
         end else if (ix >= `RXMF_IDX_LEN03 && ix < `RXMF_IDX_LEN03 + 12'h004) begin
            rxmf_decode = {`RXMF_K_LEN, 2'b00, ix[1:0], 7'h00};
         end else if (ix >= `RXMF_IDX_LEN45 && ix < `RXMF_IDX_LEN45 + 12'h002) begin
            rxmf_decode = {`RXMF_K_LEN, 3'b010, ix[0], 7'h00};
         end else if (ix >= `RXMF_IDX_LEN67 && ix < `RXMF_IDX_LEN67 + 12'h002) begin
            rxmf_decode = {`RXMF_K_LEN, 3'b011, ix[0], 7'h00};
         end else if (ix >= `RXMF_IDX_LEN89 && ix < `RXMF_IDX_LEN89 + 12'h002) begin
            rxmf_decode = {`RXMF_K_LEN, 3'b100, ix[0], 7'h00};
         end else if (ix == `RXMF_IDX_CTRL) begin
            rxmf_decode = {`RXMF_K_CTRL, 4'h0, 7'h00};
         end else if (ix == `RXMF_IDX_CTRL2) begin
            rxmf_decode = {`RXMF_K_CTRL2, 4'h0, 7'h00};
         end else if (ix == `RXMF_IDX_STATUS) begin
            rxmf_decode = {`RXMF_K_STATUS, 4'h0, 7'h00};
         end else if (ix == `RXMF_IDX_MCCTL) begin
            rxmf_decode = {`RXMF_K_MCCTL, 4'h0, 7'h00};
         end
      end
   endfunction

   // Storage. The tables have no reset; software fills them before enabling.
   // hash table words
   reg [31:0] hash_mem [0:31];
   reg [15:0] val_mem [0:639];
   reg [7:0] mask_lo_mem [0:127];
   reg [1:0] mask_hi_mem [0:127];
   reg [`RXMF_LEN_W-1:0] len_mem [0:9];

   reg [7:0] ctrl_reg;
   reg [1:0] ctrl2_reg;
   reg [9:0] status_reg;
   reg [1:0] mc_off_reg;
   reg mc_stat_reg;

   reg aw_have_reg;
   reg w_have_reg;
   reg [11:0] aw_idx_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;

   reg [10:0] pos_reg;
   reg [9:0] fail_reg;
   reg [9:0] done_reg;
   reg [47:0] dest_reg;
   reg mc_eval_reg;

   // Write channel handshakes.
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_wr = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   wire aw_have_next = (aw_have_reg | aw_take) & ~do_wr;
   wire w_have_next = (w_have_reg | w_take) & ~do_wr;
   wire bvalid_next = do_wr | (s_axi_bvalid & ~s_axi_bready);
   wire [14:0] wdec = rxmf_decode(aw_idx_reg);
   wire [3:0] wkind = wdec[14:11];
   wire [3:0] wsel = wdec[10:7];
   wire [6:0] wn = wdec[6:0];
   // A partial-word write is answered but not applied, so no table word
   // is ever left half updated.
   wire wr_full = (wstrb_reg == 4'hf);
   wire wr_en = do_wr & wr_full & (wkind != `RXMF_K_NONE);

   // Read channel.
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire [14:0] rdec = rxmf_decode(s_axi_araddr[13:2]);
   wire [3:0] rkind = rdec[14:11];
   wire [3:0] rsel = rdec[10:7];
   wire [6:0] rn = rdec[6:0];
   reg [31:0] rd_word;

   always @* begin
      rd_word = 32'h0000_0000;
      case (rkind)
         `RXMF_K_HASH: rd_word = hash_mem[rn[4:0]];
         `RXMF_K_VAL: rd_word = {16'h0000, val_mem[{rsel[2:0], rn}]};
         `RXMF_K_MASK: rd_word = {24'h00_0000, mask_lo_mem[rn]};
         `RXMF_K_MASK89: rd_word = {30'h0000_0000, mask_hi_mem[rn]};
         `RXMF_K_LEN: rd_word = {21'h00_0000, len_mem[rsel]};
         `RXMF_K_CTRL: rd_word = {24'h00_0000, ctrl_reg};
         `RXMF_K_CTRL2: rd_word = {30'h0000_0000, ctrl2_reg};
         `RXMF_K_STATUS: rd_word = {22'h00_0000, status_reg};
         `RXMF_K_MCCTL: rd_word = {23'h00_0000, mc_stat_reg, 6'h00, mc_off_reg};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Receive side: per-filter compare at the current byte position.
   wire byte_in = ce & rx_valid;
   wire in_window = (pos_reg < `RXMF_FLEX_BYTES);
   wire [11:0] pos_p1 = {1'b0, pos_reg} + 12'h001;
   wire [9:0] flex_en = {ctrl2_reg, ctrl_reg};
   wire [9:0] mask_now = {mask_hi_mem[pos_reg[6:0]], mask_lo_mem[pos_reg[6:0]]};
   wire [9:0] mism;
   wire [9:0] reach;
   wire [9:0] pass;

   genvar gi;
   generate
      for (gi = 0; gi < 10; gi = gi + 1) begin : g_flex
         localparam [3:0] FNUM = gi;
         wire [15:0] pair_word = val_mem[{FNUM[3:1], pos_reg[6:0]}];
         // even filter low byte, odd filter high byte
         wire [7:0] ref_byte = FNUM[0] ? pair_word[15:8] : pair_word[7:0];
         assign mism[gi] = in_window & mask_now[gi] & (rx_data != ref_byte);
         assign reach[gi] = ({1'b0, len_mem[gi]} == pos_p1);
         assign pass[gi] = byte_in & flex_en[gi] & ~fail_reg[gi] & ~mism[gi] & ~done_reg[gi] & reach[gi];
      end
   endgenerate

   function [9:0] rxmf_mc_index;
      input [1:0] off;
      input [47:0] dest;
      begin
         case (off)
            2'b00: rxmf_mc_index = dest[47:38];
            2'b01: rxmf_mc_index = dest[46:37];
            2'b10: rxmf_mc_index = dest[45:36];
            default: rxmf_mc_index = dest[43:34];
         endcase
      end
   endfunction

   wire [9:0] mc_idx = rxmf_mc_index(mc_off_reg, dest_reg);
   wire [31:0] mc_word = hash_mem[mc_idx[9:5]];
   // word and bit select
   // Only group frames are looked up; the group bit is the first bit on the wire.
   wire mc_hit_now = mc_eval_reg & dest_reg[0] & mc_word[mc_idx[4:0]];

   // Software-visible control and status.
   wire [9:0] stat_clr = (wr_en && wkind == `RXMF_K_STATUS) ? wdata_reg[9:0] : 10'h000;
   wire mc_clr = wr_en && wkind == `RXMF_K_MCCTL && wdata_reg[`RXMF_MCCTL_HIT_BIT];

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `RXMF_CTRL_RST;
      end else if (ce && wr_en && wkind == `RXMF_K_CTRL) begin
         ctrl_reg <= wdata_reg[7:0];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl2_reg <= `RXMF_CTRL2_RST;
      end else if (ce && wr_en && wkind == `RXMF_K_CTRL2) begin
         ctrl2_reg <= wdata_reg[1:0];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         mc_off_reg <= `RXMF_MCOFF_RST;
      end else if (ce && wr_en && wkind == `RXMF_K_MCCTL) begin
         mc_off_reg <= wdata_reg[1:0];
      end
   end

   // sticky match, set beats clear
   // A match in the same cycle as a clear survives, so no event is lost.
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= 10'h000;
      end else if (ce) begin
         status_reg <= (status_reg & ~stat_clr) | pass;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         mc_stat_reg <= 1'b0;
      end else if (ce) begin
         mc_stat_reg <= (mc_stat_reg & ~mc_clr) | mc_hit_now;
      end
   end

   // Table writes. Reserved bits are simply not stored.
   always @(posedge aclk) begin
      if (ce && wr_en) begin
         if (wkind == `RXMF_K_HASH) begin
            hash_mem[wn[4:0]] <= wdata_reg;
         end
         if (wkind == `RXMF_K_VAL) begin
            val_mem[{wsel[2:0], wn}] <= wdata_reg[15:0];
         end
         if (wkind == `RXMF_K_MASK) begin
            mask_lo_mem[wn] <= wdata_reg[7:0];
         end
         if (wkind == `RXMF_K_MASK89) begin
            mask_hi_mem[wn] <= wdata_reg[1:0];
         end
         if (wkind == `RXMF_K_LEN) begin
            len_mem[wsel] <= wdata_reg[`RXMF_LEN_W-1:0];
         end
      end
   end

   // Bus write channel.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RXMF_RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_idx_reg <= 12'h000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (ce) begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         s_axi_bvalid <= bvalid_next;
         s_axi_awready <= ~aw_have_next & ~bvalid_next;
         s_axi_wready <= ~w_have_next & ~bvalid_next;
         if (aw_take) begin
            aw_idx_reg <= s_axi_awaddr[13:2];
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bresp <= (wkind == `RXMF_K_NONE) ? `RXMF_RESP_SLVERR : `RXMF_RESP_OKAY;
         end
      end
   end

   // Bus read channel. Data is captured at the address handshake, so it
   // stays put however long the master holds off rready.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RXMF_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else if (ce) begin
         s_axi_rvalid <= rvalid_next;
         s_axi_arready <= ~rvalid_next;
         if (ar_take) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rkind == `RXMF_K_NONE) ? `RXMF_RESP_SLVERR : `RXMF_RESP_OKAY;
         end
      end
   end

   // Frame position.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pos_reg <= 11'h000;
      end else if (ce && rx_valid) begin
         if (rx_last) begin
            pos_reg <= 11'h000;
         end else if (pos_reg != 11'h7ff) begin
            // Saturates so a giant frame cannot wrap back into the compare window.
            pos_reg <= pos_reg + 11'h001;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         fail_reg <= 10'h000;
         done_reg <= 10'h000;
      end else if (ce && rx_valid) begin
         if (rx_last) begin
            fail_reg <= 10'h000;
            done_reg <= 10'h000;
         end else begin
            fail_reg <= fail_reg | (mism & ~done_reg);
            done_reg <= done_reg | reach;
         end
      end
   end

   // first wire byte lands in bits 7:0
   always @(posedge aclk) begin
      if (!aresetn) begin
         dest_reg <= 48'h0000_0000_0000;
      end else if (ce && rx_valid && pos_reg <= `RXMF_DEST_LAST_POS) begin
         dest_reg[{pos_reg[2:0], 3'b000} +: 8] <= rx_data;
      end
   end

   // The lookup runs one cycle after the last address byte, so the
   // table read always sees a complete address.
   always @(posedge aclk) begin
      if (!aresetn) begin
         mc_eval_reg <= 1'b0;
         mc_hit_reg <= 1'b0;
      end else if (ce) begin
         mc_eval_reg <= rx_valid && pos_reg == `RXMF_DEST_LAST_POS;
         mc_hit_reg <= mc_hit_now;
      end
   end

   // Pass pulses are registered so the outputs come straight from flip-flops.
   always @(posedge aclk) begin
      if (!aresetn) begin
         flex_pass_reg <= 10'h000;
      end else if (ce) begin
         flex_pass_reg <= pass;
      end
   end

endmodule

// ==== testbench/rxmf_filter_sva.sv ====
`timescale 1ns/1ps
module rxmf_filter_sva (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire rx_valid,
   input wire rx_last,
   input wire mc_hit_reg,
   input wire [9:0] flex_pass_reg
);
   reg [2:0] cnt_reg;
   wire sixth_byte = rx_valid && cnt_reg == 3'h5;
   // Only leading bytes are counted, and the clock enable is assumed high.
   always @(posedge aclk) begin
      if (!aresetn || (rx_valid && rx_last)) begin
         cnt_reg <= 3'h0;
      end else if (rx_valid && cnt_reg != 3'h7) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_resp_time: assert property (s_wr_taken |-> !s_axi_bvalid ##2 s_axi_bvalid)
      else $error("write response off time");
   a_rd_resp_time: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read response off time");
   a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_rd_addr_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken early");
   a_wr_addr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
   a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read not zero");
   a_mc_hit_time: assert property (mc_hit_reg |-> $past(sixth_byte, 2) || $past(sixth_byte, 3))
      else $error("hash hit off time");
   a_flex_pass_time: assert property (|flex_pass_reg |-> $past(rx_valid) || $past(rx_valid, 2))
      else $error("pass without byte");
endmodule
bind rxmf_filter rxmf_filter_sva u_rxmf_filter_sva (.*);

// ==== testbench/rxmf_line_model.sv ====
`timescale 1ns/1ps
module rxmf_line_model (
   input wire aclk,
   output logic rx_valid = 1'b0,
   output logic [7:0] rx_data = 8'h00,
   output logic rx_last = 1'b0
);
   task automatic send(input logic [7:0] f [0:15], input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         {rx_valid, rx_last, rx_data} <= {1'b1, i == n - 1, f[i]};
         // Idle data is inverted so a stale byte can never match by luck.
         repeat (gap) begin
            @(posedge aclk);
            {rx_valid, rx_last, rx_data} <= {2'b00, ~f[i]};
         end
      end
      @(posedge aclk);
      {rx_valid, rx_last, rx_data} <= {2'b00, ~rx_data};
   endtask
endmodule

// ==== testbench/rxmf_filter_bench.sv ====
`timescale 1ns/1ps
`include "rxmf_defs.vh"
module rxmf_filter_bench;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
   logic [31:0] s_axi_wdata = 32'h0, rs = 32'h5, r;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_valid, rx_last, mc_hit_reg;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] rx_data;
   wire [9:0] flex_pass_reg;
   logic [33:0] exp_q [$];
   logic [47:0] dest;
   logic [9:0] ix;
   logic [7:0] fb [0:15], tx [0:15];
   int err_total = 0, n_compared = 0;
   int fl [5] = '{8, 7, 8, 8, 8}, fp [5] = '{9, 9, 2, 9, 6};
   logic [31:0] fen [5] = '{32'h3, 32'h3, 32'h3, 32'h1, 32'h3}, fex [5] = '{32'h3, 32'h2, 32'h0, 32'h1, 32'h2};
   rxmf_filter u_rxmf_filter (.*);
   rxmf_line_model u_rxmf_line_model (.*);
   initial begin
      forever #20 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      finish_test();
   end
   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk(input logic [33:0] got, input logic [33:0] want);
      n_compared++;
      if (got !== want) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] tk;
      tk = 2'b00;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, 2'b00, d, 2'b11};
      while (tk != 2'b11) begin
         @(posedge aclk);
         tk = tk | {s_axi_awready, s_axi_wready};
         {s_axi_awvalid, s_axi_wvalid} <= ~tk;
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rr = `RXMF_RESP_OKAY);
      exp_q.push_back({rr, d});
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid} <= {a, 2'b00, 1'b1};
      do @(posedge aclk); while (!s_axi_arready);
      {s_axi_arvalid, s_axi_rready} <= 2'b01;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`RXMF_IDX_MCCTL, 32'h0);
      rd(12'h7ff, 32'h0, `RXMF_RESP_SLVERR);
      wr(`RXMF_IDX_CTRL2, 32'hffffffff);
      rd(`RXMF_IDX_CTRL2, 32'h3);
      wr(`RXMF_IDX_CTRL2, 32'h0);
      wr(`RXMF_IDX_LEN03 + 12'h3, 32'hffffffff);
      rd(`RXMF_IDX_LEN03 + 12'h3, 32'h7ff);
      for (int i = 0; i < 32; i++) begin
         r = xs();
         wr(`RXMF_IDX_HASH + i[11:0], r);
         rd(`RXMF_IDX_HASH + i[11:0], r);
         wr(`RXMF_IDX_HASH + i[11:0], 32'h0);
      end
      $display("register test done");
      for (int o = 0; o < 4; o++) begin
         for (int h = 0; h < 2; h++) begin
            r = xs();
            dest = {r[15:0], xs()};
            dest[0] = 1'b1;
            ix = o == 0 ? dest[47:38] : o == 1 ? dest[46:37] : o == 2 ? dest[45:36] : dest[43:34];
            for (int k = 0; k < 6; k++) fb[k] = dest[8 * k +: 8];
            {fb[6], fb[7]} = r[31:16];
            wr(`RXMF_IDX_MCCTL, {23'h0, 1'b1, 6'h0, o[1:0]});
            wr(`RXMF_IDX_HASH + {7'h0, ix[9:5]}, (32'h1 << ix[4:0]) ^ {32{h[0]}});
            u_rxmf_line_model.send(fb, 8, h);
            rd(`RXMF_IDX_MCCTL, {23'h0, h == 0, 6'h0, o[1:0]});
            wr(`RXMF_IDX_HASH + {7'h0, ix[9:5]}, 32'h0);
         end
      end
      $display("multicast test done");
      wr(`RXMF_IDX_CTRL2, 32'h0);
      for (int n = 0; n < 8; n++) begin
         r = xs();
         fb[n] = r[7:0];
         wr(`RXMF_IDX_VAL01 + 12'(2 * n), {16'h0, ((n > 4) ? ~r[7:0] : r[7:0]), r[7:0]});
         wr(`RXMF_IDX_MASK + 12'(n), (n == 5) ? 32'h1 : 32'h3);
      end
      wr(`RXMF_IDX_LEN03, 32'h8);
      wr(`RXMF_IDX_LEN03 + 12'h1, 32'h6);
      for (int c = 0; c < 5; c++) begin
         wr(`RXMF_IDX_CTRL, fen[c]);
         tx = fb;
         if (fp[c] < 8) tx[fp[c]] = ~tx[fp[c]];
         u_rxmf_line_model.send(tx, fl[c], c);
         rd(`RXMF_IDX_STATUS, fex[c]);
         wr(`RXMF_IDX_STATUS, 32'h3ff);
      end
      $display("flex filter test done");
      finish_test();
   end
endmodule
